// file: logic/iop_pkg.sv
// Purpose: shared constants and carriers for the four-port i/o block
// Assumes: 8-bit register file, bank 0 holds the port data registers
// Notes: bit positions of the loose control inputs are collected here
package iop_pkg;
  localparam logic [3:0] BANK_PORTS = 4'h0;
  localparam logic [3:0] ADDR_P0 = 4'h0;
  localparam logic [3:0] ADDR_P1 = 4'h1;
  localparam logic [3:0] ADDR_P2 = 4'h2;
  localparam logic [3:0] ADDR_P3 = 4'h3;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] P1_ABSENT = 8'hFF;
  localparam logic [7:0] RD_RST = 8'h00;
  // port_config_reg fields
  localparam int PCFG_CMP_OUT = 0;
  localparam int PCFG_P1_PP = 1;
  localparam int PCFG_P0_PP = 2;
  // low_ports_mode_reg fields, 1 = output
  localparam int LPM_P0_LO_OUT = 0;
  localparam int LPM_P0_HI_OUT = 1;
  localparam int LPM_P1_OUT = 2;
  // fourth-port mode register fields
  localparam int P3M_P2_PP = 0;
  localparam int P3M_ANALOG = 1;
  // timer_common_control fields
  localparam int TCC_EDGE_MODE = 7;
  localparam int TCC_P36_SEL = 6;
  localparam int TCC_LOGIC_HI = 5;
  localparam int TCC_LOGIC_LO = 4;
  // interrupt edge select codes (irq register bits 7:6)
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pu_en;
  } iop_pin_out_type;
  typedef struct packed {
    logic wake_or;
    logic wake_and;
    logic [2:0] p3_level;
    logic div_latch;
    logic div_irq;
  } iop_smr_type;
endpackage

// file: logic/iop_top.sv
// Purpose: three byte-wide i/o ports and a 4-bit port 3, with comparator and timer routing
// Assumes: one core clock; pin inputs are asynchronous and synchronised
// Notes: pin outputs are registered, so they trail the latches by a cycle
module iop_top #(
  parameter int PORT_W = 8
) (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic I_STOP_RECOVERY,
  input wire logic I_STOP_MODE,
  input wire logic I_SMALL_PKG,
  input wire logic [3:0] I_RF_BANK,
  input wire logic [3:0] I_RF_ADDR,
  input wire logic I_RF_WE,
  input wire logic I_RF_RE,
  input wire logic [7:0] I_RF_WDATA,
  input wire logic [7:0] I_PORT_CFG,
  input wire logic I_LPM_WE,
  input wire logic [7:0] I_LPM_WDATA,
  input wire logic I_P2_DIR_WE,
  input wire logic [7:0] I_P2_DIR_WDATA,
  input wire logic [7:0] I_P3_MODE,
  input wire logic [1:0] I_IRQ_EDGE_SEL,
  input wire logic [7:0] I_TIMER_COMMON,
  input wire logic I_FIRST_TIMER_B0,
  input wire logic I_THIRD_TIMER_B0,
  input wire logic I_T8_OUT,
  input wire logic I_T16_OUT,
  input wire logic [1:0] I_PU_OPT_P0,
  input wire logic I_PU_OPT_P2,
  input wire logic [7:0] I_P0_IN,
  input wire logic [7:0] I_P1_IN,
  input wire logic [7:0] I_P2_IN,
  input wire logic [3:0] I_P3_IN,
  input wire logic [1:0] I_CMP_RESULT,
  output iop_pkg::iop_pin_out_type O_P0,
  output iop_pkg::iop_pin_out_type O_P1,
  output iop_pkg::iop_pin_out_type O_P2,
  output logic [3:0] O_P3_OUT,
  output logic O_CMP_PWR,
  output logic [7:0] O_RF_RDATA,
  output logic O_RF_RVALID,
  output logic O_IRQ_ZERO,
  output logic O_IRQ_ONE,
  output logic O_IRQ_TWO,
  output logic O_EDGE_IN,
  output iop_pkg::iop_smr_type O_SMR
);
  import iop_pkg::*;

  if (PORT_W != 8) begin : g_bad_width
    $error("iop_top: only 8-bit ports are supported");
  end

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers: first stage is read by the second stage only
  localparam int SYNC_W = 31;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [7:0] p0_pin;
  logic [7:0] p1_pin;
  logic [7:0] p2_pin;
  logic [3:0] p3_pin;
  logic [1:0] cmp_pin;
  logic small_pkg;

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {I_SMALL_PKG, I_CMP_RESULT, I_P3_IN, I_P2_IN, I_P1_IN,
                  I_P0_IN};
      sync2_r <= sync1_r;
    end
  end

  assign p0_pin = sync2_r[7:0];
  assign p1_pin = sync2_r[15:8];
  assign p2_pin = sync2_r[23:16];
  assign p3_pin = sync2_r[27:24];
  assign cmp_pin = sync2_r[29:28];
  assign small_pkg = sync2_r[30];

  //////////////////////////////////////////////////////////////////////////
  // register file decode
  logic bank_hit;
  logic wr_p0;
  logic wr_p1;
  logic wr_p2;
  logic wr_p3;

  assign bank_hit = (I_RF_BANK == BANK_PORTS);
  assign wr_p0 = I_RF_WE && bank_hit && (I_RF_ADDR == ADDR_P0);
  assign wr_p1 = I_RF_WE && bank_hit && (I_RF_ADDR == ADDR_P1);
  assign wr_p2 = I_RF_WE && bank_hit && (I_RF_ADDR == ADDR_P2);
  assign wr_p3 = I_RF_WE && bank_hit && (I_RF_ADDR == ADDR_P3);

  //////////////////////////////////////////////////////////////////////////
  // output latches
  logic [7:0] p0_latch_r;
  logic [7:0] p1_latch_r;
  logic [7:0] p2_latch_r;
  logic [3:0] p3_latch_r;

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      p0_latch_r <= LATCH_RST;
      p1_latch_r <= LATCH_RST;
      p2_latch_r <= LATCH_RST;
      p3_latch_r <= LATCH_RST[3:0];
    end else begin
      if (wr_p0) begin
        p0_latch_r <= I_RF_WDATA;
      end
      if (wr_p1 && !small_pkg) begin
        p1_latch_r <= I_RF_WDATA;
      end
      if (wr_p2) begin
        p2_latch_r <= I_RF_WDATA;
      end
      if (wr_p3) begin
        p3_latch_r <= I_RF_WDATA[7:4];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // direction state; stop recovery clears ports 0 and 1, not port 2
  logic [2:0] lpm_r;
  logic [7:0] p2_dir_r;

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      lpm_r <= DIR_RST[2:0];
    end else if (I_STOP_RECOVERY) begin
      lpm_r <= DIR_RST[2:0];
    end else if (I_LPM_WE) begin
      lpm_r <= I_LPM_WDATA[2:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      p2_dir_r <= DIR_RST;
    end else if (I_P2_DIR_WE) begin
      p2_dir_r <= I_P2_DIR_WDATA;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drivers; open-drain only enables the driver for a low level
  logic [7:0] p0_dir;
  logic [7:0] p1_dir;
  logic p0_pp;
  logic p1_pp;
  logic p2_pp;

  assign p0_dir = {{4{lpm_r[LPM_P0_HI_OUT]}}, {4{lpm_r[LPM_P0_LO_OUT]}}};
  assign p1_dir = {8{lpm_r[LPM_P1_OUT] & ~small_pkg}};
  assign p0_pp = I_PORT_CFG[PCFG_P0_PP];
  assign p1_pp = I_PORT_CFG[PCFG_P1_PP];
  assign p2_pp = I_P3_MODE[P3M_P2_PP];

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_P0 <= '0;
      O_P1 <= '0;
      O_P2 <= '0;
    end else begin
      O_P0.dout <= p0_latch_r;
      O_P0.oe <= p0_dir & (p0_pp ? 8'hFF : ~p0_latch_r);
      O_P0.pu_en <= ~p0_dir &
                    {{4{I_PU_OPT_P0[1]}}, {4{I_PU_OPT_P0[0]}}};
      O_P1.dout <= p1_latch_r;
      O_P1.oe <= p1_dir & (p1_pp ? 8'hFF : ~p1_latch_r);
      O_P1.pu_en <= 8'h00;
      O_P2.dout <= p2_latch_r;
      O_P2.oe <= p2_dir_r & (p2_pp ? 8'hFF : ~p2_latch_r);
      O_P2.pu_en <= ~p2_dir_r & {8{I_PU_OPT_P2}};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // port 3 inputs, comparators and edge interrupts
  logic analog;
  logic [3:0] p3_eff;
  logic [3:0] p3_prev_r;
  logic [3:1] rise;
  logic [3:1] fall;
  logic [3:1] edge_hit;

  assign analog = I_P3_MODE[P3M_ANALOG];
  // comparator results are meaningless while powered down
  assign p3_eff[0] = p3_pin[0];
  assign p3_eff[1] = analog ? (cmp_pin[0] & ~I_STOP_MODE) : p3_pin[1];
  assign p3_eff[2] = analog ? (cmp_pin[1] & ~I_STOP_MODE) : p3_pin[2];
  assign p3_eff[3] = p3_pin[3];
  assign rise = p3_eff[3:1] & ~p3_prev_r[3:1];
  assign fall = ~p3_eff[3:1] & p3_prev_r[3:1];
  always_comb begin
    case (I_IRQ_EDGE_SEL)
      EDGE_FALL: edge_hit = fall;
      EDGE_RISE: edge_hit = rise;
      default: edge_hit = rise | fall;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      p3_prev_r <= 4'h0;
      O_IRQ_ZERO <= 1'h0;
      O_IRQ_ONE <= 1'h0;
      O_IRQ_TWO <= 1'h0;
      O_CMP_PWR <= 1'h0;
    end else begin
      p3_prev_r <= p3_eff;
      O_IRQ_TWO <= edge_hit[1];
      O_IRQ_ZERO <= edge_hit[2];
      O_IRQ_ONE <= edge_hit[3] & ~analog;
      O_CMP_PWR <= analog & ~I_STOP_MODE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wake-up and stop-recovery sources
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SMR <= '0;
    end else begin
      O_SMR.wake_or <= |p2_pin;
      O_SMR.wake_and <= &p2_pin;
      // software must select digital mode for these to wake the part
      O_SMR.p3_level <= analog ? 3'h0 : p3_pin[3:1];
      O_SMR.div_latch <= analog & p3_pin[3];
      O_SMR.div_irq <= analog & edge_hit[3];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counter/timer edge input and port 3 output routing
  logic logic_out;
  logic [3:0] p3_drive;

  always_comb begin
    case (I_TIMER_COMMON[TCC_LOGIC_HI:TCC_LOGIC_LO])
      2'h0: logic_out = I_T8_OUT & I_T16_OUT;
      2'h1: logic_out = I_T8_OUT | I_T16_OUT;
      2'h2: logic_out = ~(I_T8_OUT | I_T16_OUT);
      default: logic_out = ~(I_T8_OUT & I_T16_OUT);
    endcase
  end

  always_comb begin
    p3_drive = p3_latch_r;
    if (I_FIRST_TIMER_B0) begin
      p3_drive[0] = I_T8_OUT;
    end
    if (I_PORT_CFG[PCFG_CMP_OUT]) begin
      p3_drive[0] = p3_eff[1];
      p3_drive[3] = p3_eff[2];
    end
    if (I_THIRD_TIMER_B0) begin
      p3_drive[1] = I_T16_OUT;
    end
    if (!I_TIMER_COMMON[TCC_EDGE_MODE] && I_TIMER_COMMON[TCC_P36_SEL]) begin
      p3_drive[2] = logic_out;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_P3_OUT <= 4'h0;
      O_EDGE_IN <= 1'h0;
    end else begin
      O_P3_OUT <= p3_drive;
      O_EDGE_IN <= I_TIMER_COMMON[TCC_P36_SEL] ? p2_pin[0] :
                   p3_pin[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path: pin levels, except small-package port 1 (all ones), port 3 bits 7:4 (registered outputs) and, in analog mode, bits 3:1 (0, comparators)
  logic [7:0] rd_mux;

  always_comb begin
    case (I_RF_ADDR)
      ADDR_P0: rd_mux = p0_pin;
      ADDR_P1: rd_mux = small_pkg ? P1_ABSENT : p1_pin;
      ADDR_P2: rd_mux = p2_pin;
      ADDR_P3: rd_mux = {O_P3_OUT, (analog ? 1'h0 : p3_eff[3]),
                         p3_eff[2:0]};
      default: rd_mux = RD_RST;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RF_RDATA <= RD_RST;
      O_RF_RVALID <= 1'h0;
    end else begin
      O_RF_RVALID <= I_RF_RE && bank_hit && (I_RF_ADDR <= ADDR_P3);
      if (I_RF_RE) begin
        O_RF_RDATA <= rd_mux;
      end
    end
  end
endmodule

// file: tb/iop_props.sv
// Purpose: port checks for the four-port i/o block
// Assumes: bound to iop_top, one core clock
// Notes: pin outputs trail the latches by one edge and stop recovery by two
module iop_props (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic I_STOP_RECOVERY,
  input wire logic I_STOP_MODE,
  input wire logic I_SMALL_PKG,
  input wire logic [3:0] I_RF_BANK,
  input wire logic [3:0] I_RF_ADDR,
  input wire logic I_RF_RE,
  input wire logic [7:0] I_PORT_CFG,
  input wire logic [7:0] I_P3_MODE,
  input iop_pkg::iop_pin_out_type O_P0,
  input iop_pkg::iop_pin_out_type O_P1,
  input iop_pkg::iop_pin_out_type O_P2,
  input wire logic O_CMP_PWR,
  input wire logic [7:0] O_RF_RDATA,
  input wire logic O_RF_RVALID,
  input wire logic O_IRQ_ONE
);
  timeunit 1ns;
  timeprecision 1ps;
  import iop_pkg::*;
  logic hit;
  assign hit = I_RF_RE && I_RF_BANK == BANK_PORTS && I_RF_ADDR <= ADDR_P3;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  //////////////////////////////
  a_cmp_power: assert property (
    $past(I_NRST) |-> O_CMP_PWR == $past(I_P3_MODE[1] && !I_STOP_MODE))
    else $error("comparator power wrong");
  a_read_valid: assert property (
    $past(I_NRST) |-> O_RF_RVALID == $past(hit))
    else $error("read valid wrong");
  a_rdata_hold: assert property (
    $past(I_NRST) && !$past(I_RF_RE) |-> $stable(O_RF_RDATA))
    else $error("read data moved without a read");
  a_small_ones: assert property (
    I_SMALL_PKG && $past(I_SMALL_PKG, 2) && $past(I_NRST, 2) && hit
    && I_RF_ADDR == ADDR_P1 |=> O_RF_RDATA == P1_ABSENT)
    else $error("absent port did not read all ones");
  a_irq_digital: assert property (
    O_IRQ_ONE |-> !($past(I_P3_MODE[1]) && $past(I_P3_MODE[1], 2)
    && $past(I_P3_MODE[1], 3)))
    else $error("interrupt one raised in analog mode");
  a_recover_input: assert property (
    I_STOP_RECOVERY |-> ##2 (O_P0.oe | O_P1.oe) == DIR_RST)
    else $error("recovery left a line driving");
  a_pullup_off: assert property (
    (O_P0.oe & O_P0.pu_en) == 8'h00 && (O_P2.oe & O_P2.pu_en) == 8'h00)
    else $error("pull-up on a driven line");
  a_open_drain: assert property (
    !$past(I_PORT_CFG[2]) && !$past(I_PORT_CFG[2], 2) && $past(I_NRST, 2)
    |-> (O_P0.oe & O_P0.dout) == 8'h00)
    else $error("open-drain line drove high");
endmodule
bind iop_top iop_props u_props (.*);

// file: tb/iop_pins_model.sv
// Purpose: board around ports 0 to 2
// Assumes: board always drives every line weakly
// Notes: a line driven by the block beats the board
module iop_pins_model (
  input iop_pkg::iop_pin_out_type i_p0,
  input iop_pkg::iop_pin_out_type i_p1,
  input iop_pkg::iop_pin_out_type i_p2,
  input wire logic [7:0] i_ext0,
  input wire logic [7:0] i_ext1,
  input wire logic [7:0] i_ext2,
  output logic [7:0] o_lvl0,
  output logic [7:0] o_lvl1,
  output logic [7:0] o_lvl2
);
  timeunit 1ns;
  timeprecision 1ps;
  import iop_pkg::*;
  //////////////////////////////
  // open-drain highs have oe low, so the board shows through
  function automatic logic [7:0] res(iop_pin_out_type p, logic [7:0] x);
    return (p.oe & p.dout) | (~p.oe & x);
  endfunction
  assign o_lvl0 = res(i_p0, i_ext0);
  assign o_lvl1 = res(i_p1, i_ext1);
  assign o_lvl2 = res(i_p2, i_ext2);
endmodule

// file: tb/iop_top_tb_top.sv
// Purpose: self-checking bench for the four-port i/o block
// Assumes: inputs change 1 ns after the rising edge
// Notes: timer outputs are plain levels set by the tests
module iop_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import iop_pkg::*;
  logic I_CORE_CLK = 1'h0, I_NRST = 1'h0, I_STOP_RECOVERY = 1'h0;
  logic I_STOP_MODE = 1'h0, I_SMALL_PKG = 1'h0, I_RF_WE = 1'h0;
  logic I_RF_RE = 1'h0, I_LPM_WE = 1'h0, I_P2_DIR_WE = 1'h0;
  logic I_FIRST_TIMER_B0 = 1'h0, I_THIRD_TIMER_B0 = 1'h0;
  logic I_T8_OUT = 1'h0, I_T16_OUT = 1'h0, I_PU_OPT_P2 = 1'h1;
  logic [3:0] I_RF_BANK = 4'h0, I_RF_ADDR = 4'h0, I_P3_IN = 4'h0;
  logic [7:0] I_RF_WDATA = 8'h00, I_PORT_CFG = 8'h06, I_LPM_WDATA = 8'h00;
  logic [7:0] I_P2_DIR_WDATA = 8'h00, I_P3_MODE = 8'h00;
  logic [7:0] I_TIMER_COMMON = 8'h00, ext0 = 8'h00, ext1 = 8'h00;
  logic [1:0] I_IRQ_EDGE_SEL = 2'h0, I_PU_OPT_P0 = 2'h3, I_CMP_RESULT = 2'h0;
  logic [7:0] I_P0_IN, I_P1_IN, I_P2_IN, O_RF_RDATA, ext2 = 8'h00;
  logic [7:0] d, e, m, w, n;
  logic [3:0] O_P3_OUT;
  logic O_CMP_PWR, O_RF_RVALID, O_IRQ_ZERO, O_IRQ_ONE, O_IRQ_TWO, O_EDGE_IN;
  iop_pin_out_type O_P0, O_P1, O_P2;
  iop_smr_type O_SMR;
  int n_errors = 0, checks_done = 0, s;
  always #2.5 I_CORE_CLK = ~I_CORE_CLK;
  iop_top dut (.*);
  iop_pins_model u_pins (.i_p0(O_P0), .i_p1(O_P1), .i_p2(O_P2),
    .i_ext0(ext0), .i_ext1(ext1), .i_ext2(ext2),
    .o_lvl0(I_P0_IN), .o_lvl1(I_P1_IN), .o_lvl2(I_P2_IN));
  //////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge I_CORE_CLK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    I_RF_ADDR = a;
    I_RF_WDATA = v;
    I_RF_WE = 1'h1;
    cyc(1);
    I_RF_WE = 1'h0;
    cyc(1);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] v);
    logic hit;
    hit = I_RF_BANK == BANK_PORTS && a <= ADDR_P3;
    I_RF_ADDR = a;
    I_RF_RE = 1'h1;
    cyc(1);
    I_RF_RE = 1'h0;
    chk({7'h00, O_RF_RVALID}, {7'h00, hit});
    if (hit) chk(O_RF_RDATA, v);
    cyc(1);
  endtask
  task automatic lpm(input logic [7:0] v);
    I_LPM_WDATA = v;
    I_LPM_WE = 1'h1;
    cyc(1);
    I_LPM_WE = 1'h0;
    cyc(1);
  endtask
  // pulses on one interrupt line over a rise and a fall of one pin
  task automatic pulses(input int b, output logic [7:0] c,
                        output logic [7:0] v);
    c = 8'h00;
    v = 8'h00;
    for (int k = 0; k < 16; k++) begin
      I_P3_IN[b] = k >= 1 && k < 8;
      cyc(1);
      c += (b == 3) ? O_IRQ_ONE : (b == 2) ? O_IRQ_ZERO : O_IRQ_TWO;
      v += O_SMR.div_irq;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #50us;
    n_errors++;
    report_and_stop();
  end
  //////////////////////////////
  initial begin
    void'($urandom(41715));
    cyc(8);
    I_NRST = 1'h1;
    cyc(2);
    chk(O_P0.oe | O_P1.oe, DIR_RST);
    chk(O_P2.oe, DIR_RST);
    $display("test reset done");
    m = $urandom;
    w = $urandom;
    e = $urandom;
    ext2 = e;
    I_P3_MODE = 8'h01;
    I_P2_DIR_WDATA = m;
    I_P2_DIR_WE = 1'h1;
    cyc(1);
    I_P2_DIR_WE = 1'h0;
    wr(ADDR_P2, w);
    cyc(4);
    chk(O_P2.oe, m);
    chk(O_P2.pu_en, ~m);
    rdc(ADDR_P2, (m & w) | (~m & e));
    for (s = 0; s < 2; s++) begin
      ext2 = {8{s == 0}};
      wr(ADDR_P2, ext2);
      cyc(4);
      chk({O_SMR.wake_or, O_SMR.wake_and}, {2{s == 0}});
    end
    wr(ADDR_P2, w);
    I_P3_MODE = 8'h00;
    cyc(4);
    chk(O_P2.oe, m & ~w);
    $display("test port2 done");
    d = $urandom;
    e = $urandom;
    ext0 = e;
    ext1 = e;
    lpm(8'h01);
    wr(ADDR_P0, d);
    wr(ADDR_P1, ~d);
    cyc(4);
    chk(O_P0.oe, 8'h0F);
    chk(O_P0.pu_en, 8'hF0);
    rdc(ADDR_P0, {e[7:4], d[3:0]});
    I_PORT_CFG = 8'h00;
    cyc(4);
    chk(O_P0.oe, 8'h0F & ~d);
    rdc(ADDR_P0, {e[7:4], d[3:0] & e[3:0]});
    I_PORT_CFG = 8'h06;
    lpm(8'h06);
    cyc(3);
    chk(O_P0.oe, 8'hF0);
    chk(O_P1.oe, 8'hFF);
    chk(O_P1.dout, ~d);
    I_STOP_RECOVERY = 1'h1;
    cyc(1);
    I_STOP_RECOVERY = 1'h0;
    cyc(3);
    chk(O_P0.oe | O_P1.oe, DIR_RST);
    chk(O_P2.oe, m & ~w);
    I_SMALL_PKG = 1'h1;
    cyc(3);
    wr(ADDR_P1, 8'h00);
    rdc(ADDR_P1, P1_ABSENT);
    I_SMALL_PKG = 1'h0;
    chk(O_P1.dout, ~d);
    I_RF_BANK = 4'h1;
    rdc(ADDR_P0, 8'h00);
    I_RF_BANK = BANK_PORTS;
    rdc(4'h4, 8'h00);
    $display("test ports 0 1 done");
    w = $urandom;
    I_P3_IN = $urandom;
    I_CMP_RESULT = $urandom;
    wr(ADDR_P3, w);
    cyc(3);
    chk(O_P3_OUT, w[7:4]);
    rdc(ADDR_P3, {w[7:4], I_P3_IN});
    I_P3_MODE = 8'h02;
    I_PORT_CFG = 8'h01;
    cyc(4);
    rdc(ADDR_P3, {I_CMP_RESULT[1], w[6:5], I_CMP_RESULT[0], 1'h0,
                  I_CMP_RESULT, I_P3_IN[0]});
    chk(O_P3_OUT, {I_CMP_RESULT[1], w[6:5], I_CMP_RESULT[0]});
    chk({7'h00, O_CMP_PWR}, 8'h01);
    I_STOP_MODE = 1'h1;
    cyc(2);
    chk({7'h00, O_CMP_PWR}, 8'h00);
    I_STOP_MODE = 1'h0;
    I_PORT_CFG = 8'h00;
    I_P3_MODE = 8'h00;
    I_FIRST_TIMER_B0 = 1'h1;
    I_T8_OUT = 1'h1;
    for (s = 0; s < 4; s++) begin
      I_TIMER_COMMON = {2'h1, s[1:0], 4'h0};
      cyc(3);
      chk(O_P3_OUT, {w[7], s[0], w[5], 1'h1});
    end
    I_THIRD_TIMER_B0 = 1'h1;
    I_T16_OUT = 1'h1;
    cyc(3);
    chk(O_P3_OUT, {w[7], 1'h0, 1'h1, 1'h1});
    I_THIRD_TIMER_B0 = 1'h0;
    I_T16_OUT = 1'h0;
    $display("test port3 done");
    I_TIMER_COMMON = 8'h00;
    I_P3_IN = 4'h0;
    cyc(6);
    for (s = 0; s < 3; s++) begin
      I_IRQ_EDGE_SEL = s[1:0];
      pulses(1, n, d);
      chk(n, (s == 2) ? 8'h02 : 8'h01);
      pulses(2, n, d);
      chk(n, (s == 2) ? 8'h02 : 8'h01);
    end
    for (s = 0; s < 2; s++) begin
      I_P3_MODE = {6'h00, s[0], 1'h0};
      cyc(6);
      pulses(3, n, d);
      chk(n, (s == 0) ? 8'h02 : 8'h00);
      chk(d, (s == 0) ? 8'h00 : 8'h02);
    end
    I_P3_IN = 4'hE;
    cyc(4);
    chk({4'h0, O_SMR.p3_level, O_SMR.div_latch}, 8'h01);
    I_P3_MODE = 8'h00;
    cyc(2);
    chk({4'h0, O_SMR.p3_level, O_SMR.div_latch}, 8'h0E);
    $display("test interrupts done");
    I_P3_MODE = 8'h00;
    I_P3_IN[1] = ~I_P2_IN[0];
    I_TIMER_COMMON = 8'h80;
    cyc(4);
    chk({7'h00, O_EDGE_IN}, {7'h00, I_P3_IN[1]});
    I_TIMER_COMMON = 8'hC0;
    cyc(4);
    chk({7'h00, O_EDGE_IN}, {7'h00, I_P2_IN[0]});
    $display("test edge input done");
    report_and_stop();
  end
endmodule
